//--- include/rpc_pkg.sv
// Package for the region protection checker: register map, field layout, access and cause types
package rpc_pkg;
    localparam int          RPC_ADDR_W      = 8;
    localparam int          RPC_CAUSE_W     = 5;
    // Register byte addresses
    localparam logic [7:0]  RPC_OFF_CTRL    = 8'h00;
    localparam logic [7:0]  RPC_OFF_IRQSTAT = 8'h04;
    localparam logic [7:0]  RPC_OFF_IRQMASK = 8'h08;
    localparam logic [7:0]  RPC_OFF_PERMA   = 8'h0C;
    localparam logic [7:0]  RPC_OFF_PERMB   = 8'h10;
    localparam logic [7:0]  RPC_OFF_FLTPC   = 8'h14;
    localparam logic [7:0]  RPC_OFF_FLTCAUS = 8'h18;
    localparam logic [7:0]  RPC_OFF_REGION  = 8'h40;
    localparam logic [7:0]  RPC_OFF_SUBSEL  = 8'h60;
    localparam logic [7:0]  RPC_REG_STRIDE  = 8'h04;
    // Region register fields
    localparam int          RPC_BASE_LSB    = 12;
    localparam int          RPC_SIZE_LSB    = 1;
    localparam int          RPC_SIZE_W      = 5;
    localparam int          RPC_VALID_BIT   = 0;
    localparam logic [4:0]  RPC_SIZE_MIN    = 5'h0B;
    localparam int          RPC_SUB_SHIFT   = 3;
    localparam int          RPC_AP_W        = 4;
    localparam int          RPC_SUB_N       = 16;
    localparam int          RPC_CTRL_EN_BIT = 0;
    // Cause bit positions
    localparam int          RPC_C_IPROT     = 0;
    localparam int          RPC_C_DPROT     = 1;
    localparam int          RPC_C_IMISS     = 2;
    localparam int          RPC_C_DMISS     = 3;
    localparam int          RPC_C_MULTI     = 4;
    // Permission field encodings
    localparam logic [3:0]  RPC_AP_PR       = 4'h0;
    localparam logic [3:0]  RPC_AP_PRX      = 4'h1;
    localparam logic [3:0]  RPC_AP_PRW      = 4'h2;
    localparam logic [3:0]  RPC_AP_PRWX     = 4'h3;
    localparam logic [3:0]  RPC_AP_R        = 4'h4;
    localparam logic [3:0]  RPC_AP_RX       = 4'h5;
    localparam logic [3:0]  RPC_AP_RW       = 4'h6;
    localparam logic [3:0]  RPC_AP_RWX      = 4'h7;
    localparam logic [3:0]  RPC_AP_PRW_UR   = 4'h8;
    localparam logic [3:0]  RPC_AP_PRW_URX  = 4'h9;

    typedef struct packed {
        logic        valid;
        logic        isFetch;
        logic        isWrite;
        logic        privileged;
        logic [31:0] addr;
        logic [31:0] instPc;
    } rpc_access_type;

    typedef struct packed {
        logic        multiHit;
        logic        dataMiss;
        logic        instMiss;
        logic        dataProt;
        logic        instProt;
    } rpc_cause_type;
endpackage : rpc_pkg

//--- hw/rpc_checker.sv
// Region protection checker: region match, subregion permission select, exceptions and register port
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Denied fetch raises instruction protection exception
// - Denied data access raises data protection exception
// - Fetch missing all regions raises instruction miss
// - Data access missing all regions raises miss
// - Faulting access is blocked, never performed
// - Faulting instruction address is handed out
// - Several hit regions raise multiple-hit error
// - Region splits into sixteen equal subregions
// - Subregion index counts upward from base
// - Subregion select bit picks set A/B
// - Each set holds one field per region
// - Select zero means A, one means B
// - Only valid regions take part
// - Global enable clear suppresses every exception
// - Subregion found before permission is chosen
module rpc_checker #(
    parameter int REGIONS = 8
) (
    input  wire logic                             core_clk,
    input  wire logic                             reset,
    input  wire rpc_pkg::rpc_access_type          access,
    output logic                                  accessAbort,
    output var rpc_pkg::rpc_cause_type            cause,
    output logic [31:0]                           causePc,
    input  wire logic [rpc_pkg::RPC_ADDR_W-1:0]   regAddr,
    input  wire logic [31:0]                      regWdata,
    input  wire logic                             regWrite,
    input  wire logic                             regRead,
    output logic [31:0]                           regRdata,
    output logic                                  irq
);
    import rpc_pkg::*;

    logic [31:0]              regionCfg [REGIONS];
    logic [RPC_SUB_N-1:0]     subregion_select_reg [REGIONS];
    logic [REGIONS*RPC_AP_W-1:0] permission_set_a;
    logic [REGIONS*RPC_AP_W-1:0] permission_set_b;
    logic                     enable;
    logic [RPC_CAUSE_W-1:0]   irqStatus;
    logic [RPC_CAUSE_W-1:0]   irqMask;
    logic [31:0]              faultPc;
    logic [RPC_CAUSE_W-1:0]   faultCause;
    logic [31:0]              rdData;

    logic [31:0]              next_regionCfg [REGIONS];
    logic [RPC_SUB_N-1:0]     next_subSel [REGIONS];
    logic [REGIONS*RPC_AP_W-1:0] next_permA;
    logic [REGIONS*RPC_AP_W-1:0] next_permB;
    logic                     next_enable;
    logic [RPC_CAUSE_W-1:0]   next_irqStatus;
    logic [RPC_CAUSE_W-1:0]   next_irqMask;
    logic [31:0]              next_faultPc;
    logic [RPC_CAUSE_W-1:0]   next_faultCause;
    logic [31:0]              next_rdData;

    // Effective size field; encodings below the smallest region are taken as 4 KB
    function automatic logic [4:0] eff_size(input logic [31:0] cfg);
        logic [4:0] s;
        s = cfg[RPC_SIZE_LSB +: RPC_SIZE_W];
        eff_size = (s < RPC_SIZE_MIN) ? RPC_SIZE_MIN : s;
    endfunction : eff_size

    function automatic logic region_hit(input logic [31:0] cfg, input logic [31:0] addr);
        logic [4:0]  s;
        logic [31:0] mask;
        s = eff_size(cfg);
        mask = ~((32'h0000_0001 << (6'(s) + 6'h01)) - 32'h0000_0001);
        region_hit = ((addr & mask) == ({cfg[31:RPC_BASE_LSB], 12'h000} & mask));
    endfunction : region_hit

    // Subregion index: the top four offset bits inside the region
    function automatic logic [3:0] sub_index(input logic [31:0] cfg, input logic [31:0] addr);
        logic [4:0] s;
        s = eff_size(cfg);
        sub_index = 4'(addr >> (s - 5'(RPC_SUB_SHIFT)));
    endfunction : sub_index

    function automatic logic ap_allows(input logic [3:0] ap, input logic priv,
                                       input logic fetch, input logic write);
        logic r;
        logic w;
        logic x;
        r = 1'b0;
        w = 1'b0;
        x = 1'b0;
        case (ap)
            RPC_AP_PR:      begin r = priv; end
            RPC_AP_PRX:     begin r = priv; x = priv; end
            RPC_AP_PRW:     begin r = priv; w = priv; end
            RPC_AP_PRWX:    begin r = priv; w = priv; x = priv; end
            RPC_AP_R:       begin r = 1'b1; end
            RPC_AP_RX:      begin r = 1'b1; x = 1'b1; end
            RPC_AP_RW:      begin r = 1'b1; w = 1'b1; end
            RPC_AP_RWX:     begin r = 1'b1; w = 1'b1; x = 1'b1; end
            RPC_AP_PRW_UR:  begin r = 1'b1; w = priv; end
            RPC_AP_PRW_URX: begin r = 1'b1; w = priv; x = ~priv; end
            default:        begin r = 1'b0; end
        endcase
        ap_allows = fetch ? x : (write ? w : r);
    endfunction : ap_allows

    // Per-region match and permission lookup
    logic [REGIONS-1:0] hitVec;
    logic [REGIONS-1:0] allowVec;
    genvar g;
    generate
        for (g = 0; g < REGIONS; g++) begin : gRegion
            logic [3:0] subIdx;
            logic       useB;
            logic [3:0] apSel;
            assign hitVec[g] = regionCfg[g][RPC_VALID_BIT] & region_hit(regionCfg[g], access.addr);
            assign subIdx = sub_index(regionCfg[g], access.addr);
            assign useB = subregion_select_reg[g][subIdx];
            assign apSel = useB ? permission_set_b[g*RPC_AP_W +: RPC_AP_W]
                                : permission_set_a[g*RPC_AP_W +: RPC_AP_W];
            assign allowVec[g] = ap_allows(apSel, access.privileged, access.isFetch, access.isWrite);
        end
    endgenerate

    logic check;
    logic anyHit;
    logic multiHit;
    logic denied;
    assign anyHit = |hitVec;
    assign multiHit = anyHit & ((hitVec & (hitVec - REGIONS'(1))) != '0);
    assign denied = |(hitVec & ~allowVec);
    assign check = access.valid & enable;

    always_comb begin
        cause.multiHit = check & multiHit;
        cause.instProt = check & ~multiHit & access.isFetch & denied;
        cause.dataProt = check & ~multiHit & ~access.isFetch & denied;
        cause.instMiss = check & ~anyHit & access.isFetch;
        cause.dataMiss = check & ~anyHit & ~access.isFetch;
    end

    assign accessAbort = |cause;
    assign causePc = access.instPc;
    assign irq = |(irqStatus & irqMask);
    assign regRdata = rdData;

    function automatic logic reg_sel(input logic [RPC_ADDR_W-1:0] a, input logic [7:0] off);
        reg_sel = (a == off);
    endfunction : reg_sel

    always_comb begin
        next_regionCfg = regionCfg;
        next_subSel = subregion_select_reg;
        next_permA = permission_set_a;
        next_permB = permission_set_b;
        next_enable = enable;
        next_irqMask = irqMask;
        next_irqStatus = irqStatus;
        next_faultPc = faultPc;
        next_faultCause = faultCause;
        next_rdData = 32'h0000_0000;
        if (regWrite) begin
            if (reg_sel(regAddr, RPC_OFF_CTRL)) begin
                next_enable = regWdata[RPC_CTRL_EN_BIT];
            end
            if (reg_sel(regAddr, RPC_OFF_IRQSTAT)) begin
                next_irqStatus = irqStatus & ~regWdata[RPC_CAUSE_W-1:0];
            end
            if (reg_sel(regAddr, RPC_OFF_IRQMASK)) begin
                next_irqMask = regWdata[RPC_CAUSE_W-1:0];
            end
            if (reg_sel(regAddr, RPC_OFF_PERMA)) begin
                next_permA = regWdata[REGIONS*RPC_AP_W-1:0];
            end
            if (reg_sel(regAddr, RPC_OFF_PERMB)) begin
                next_permB = regWdata[REGIONS*RPC_AP_W-1:0];
            end
            for (int i = 0; i < REGIONS; i++) begin
                if (reg_sel(regAddr, RPC_OFF_REGION + 8'(i) * RPC_REG_STRIDE)) begin
                    next_regionCfg[i] = {regWdata[31:RPC_BASE_LSB], 6'h00,
                                         regWdata[RPC_SIZE_LSB +: RPC_SIZE_W], regWdata[RPC_VALID_BIT]};
                end
                if (reg_sel(regAddr, RPC_OFF_SUBSEL + 8'(i) * RPC_REG_STRIDE)) begin
                    next_subSel[i] = regWdata[RPC_SUB_N-1:0];
                end
            end
        end
        // Hardware set wins over a same-cycle clear
        next_irqStatus = next_irqStatus | cause;
        if (accessAbort) begin
            next_faultPc = access.instPc;
            next_faultCause = cause;
        end
        if (regRead) begin
            if (reg_sel(regAddr, RPC_OFF_CTRL)) begin
                next_rdData[RPC_CTRL_EN_BIT] = enable;
            end
            if (reg_sel(regAddr, RPC_OFF_IRQSTAT)) begin
                next_rdData[RPC_CAUSE_W-1:0] = irqStatus;
            end
            if (reg_sel(regAddr, RPC_OFF_IRQMASK)) begin
                next_rdData[RPC_CAUSE_W-1:0] = irqMask;
            end
            if (reg_sel(regAddr, RPC_OFF_PERMA)) begin
                next_rdData[REGIONS*RPC_AP_W-1:0] = permission_set_a;
            end
            if (reg_sel(regAddr, RPC_OFF_PERMB)) begin
                next_rdData[REGIONS*RPC_AP_W-1:0] = permission_set_b;
            end
            if (reg_sel(regAddr, RPC_OFF_FLTPC)) begin
                next_rdData = faultPc;
            end
            if (reg_sel(regAddr, RPC_OFF_FLTCAUS)) begin
                next_rdData[RPC_CAUSE_W-1:0] = faultCause;
            end
            for (int i = 0; i < REGIONS; i++) begin
                if (reg_sel(regAddr, RPC_OFF_REGION + 8'(i) * RPC_REG_STRIDE)) begin
                    next_rdData = regionCfg[i];
                end
                if (reg_sel(regAddr, RPC_OFF_SUBSEL + 8'(i) * RPC_REG_STRIDE)) begin
                    next_rdData[RPC_SUB_N-1:0] = subregion_select_reg[i];
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < REGIONS; i++) begin
                regionCfg[i] <= 32'h0000_0000;
                subregion_select_reg[i] <= '0;
            end
            permission_set_a <= '0;
            permission_set_b <= '0;
            enable <= 1'b0;
            irqStatus <= '0;
            irqMask <= '0;
            faultPc <= 32'h0000_0000;
            faultCause <= '0;
            rdData <= 32'h0000_0000;
        end else begin
            regionCfg <= next_regionCfg;
            subregion_select_reg <= next_subSel;
            permission_set_a <= next_permA;
            permission_set_b <= next_permB;
            enable <= next_enable;
            irqStatus <= next_irqStatus;
            irqMask <= next_irqMask;
            faultPc <= next_faultPc;
            faultCause <= next_faultCause;
            rdData <= next_rdData;
        end
    end
endmodule : rpc_checker
`default_nettype wire

//--- tb/rpc_chk.sv
// Assertion checker on the region protection checker ports
`timescale 1ns/10ps
`default_nettype none
module rpc_chk #(
    parameter int REGIONS = 8
) (
    input wire logic                    core_clk,
    input wire logic                    reset,
    input wire rpc_pkg::rpc_access_type access,
    input wire logic                    accessAbort,
    input wire rpc_pkg::rpc_cause_type  cause,
    input wire logic [31:0]             causePc,
    input wire logic [7:0]              regAddr,
    input wire logic [31:0]             regWdata,
    input wire logic                    regWrite,
    input wire logic                    regRead,
    input wire logic [31:0]             regRdata,
    input wire logic                    irq
);
    import rpc_pkg::*;
    logic enabled;
    logic next_enabled;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // Mirror of the global enable, effective the cycle after the write
    always_comb begin
        next_enabled = enabled;
        if (regWrite && regAddr == RPC_OFF_CTRL) begin
            next_enabled = regWdata[RPC_CTRL_EN_BIT];
        end
    end
    always_ff @(posedge core_clk) begin
        enabled <= reset ? 1'b0 : next_enabled;
    end
    chk_abort_cause: assert property (access.valid |-> accessAbort == (cause != 5'h00))
        else $error("abort does not follow cause");
    chk_idle_quiet: assert property (!access.valid |-> !accessAbort && cause == 5'h00)
        else $error("cause without an access");
    chk_pc_copy: assert property (access.valid && accessAbort |-> causePc == access.instPc)
        else $error("fault pc not the instruction address");
    chk_one_cause: assert property ($onehot0(cause))
        else $error("more than one cause at once");
    chk_fetch_side: assert property (access.isFetch |-> !cause.dataProt && !cause.dataMiss)
        else $error("data cause on a fetch");
    chk_data_side: assert property (!access.isFetch |-> !cause.instProt && !cause.instMiss)
        else $error("fetch cause on a data access");
    chk_enable_off: assert property (!enabled |-> cause == 5'h00 && !accessAbort)
        else $error("exception while disabled");
    chk_multi_abort: assert property (cause.multiHit |-> accessAbort && access.valid)
        else $error("multiple hit not aborted");
    cover property (cause.instMiss);
    cover property (cause.dataProt);
    cover property (cause.multiHit);
endmodule : rpc_chk
bind rpc_checker rpc_chk #(.REGIONS(REGIONS)) u_chk (.core_clk(core_clk), .reset(reset), .access(access),
    .accessAbort(accessAbort), .cause(cause), .causePc(causePc), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .irq(irq));
`default_nettype wire

//--- tb/rpc_core_model.sv
// Pipeline model presenting fetch and data accesses, one per cycle
`timescale 1ns/10ps
`default_nettype none
module rpc_core_model (
    input  wire logic                    core_clk,
    output var rpc_pkg::rpc_access_type  access
);
    import rpc_pkg::*;
    initial access = '0;
    task automatic present(input logic f, w, p, input logic [31:0] a, pc);
        @(posedge core_clk);
        access <= '{1'b1, f, w, p, a, pc};
    endtask : present
    // Dropped bus shows inverted values, never the stale access
    task automatic drop();
        @(posedge core_clk);
        access <= '{1'b0, 1'b0, 1'b0, 1'b0, ~access.addr, ~access.instPc};
    endtask : drop
endmodule : rpc_core_model
`default_nettype wire

//--- tb/tb.sv
// Self-checking testbench for the region protection checker
`timescale 1ns/10ps
`default_nettype none
module tb;
    import rpc_pkg::*;
    logic           core_clk = 1'b0;
    logic           reset = 1'b1;
    rpc_access_type access;
    logic           accessAbort;
    rpc_cause_type  cause;
    logic [31:0]    causePc;
    logic [7:0]     regAddr = 8'h00;
    logic [31:0]    regWdata = 32'h0;
    logic           regWrite = 1'b0;
    logic           regRead = 1'b0;
    logic [31:0]    regRdata;
    logic           irq;
    int             n_errors = 0;
    int             comparisons = 0;
    int             cycles = 0;
    always #25 core_clk = ~core_clk;
    rpc_core_model core (.core_clk(core_clk), .access(access));
    rpc_checker #(.REGIONS(8)) dut (.core_clk(core_clk), .reset(reset), .access(access),
        .accessAbort(accessAbort), .cause(cause), .causePc(causePc), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .irq(irq));
    task automatic complete_run();
        if (n_errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_errors++;
            complete_run();
        end
    end
    task automatic cmp(input logic [31:0] got, exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWrite <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1;
        cmp(regRdata, exp, "read data");
    endtask : rd
    // Cause, abort and stacked address all judged in the access cycle
    task automatic acc(input logic f, w, p, input logic [31:0] a, input logic [4:0] exp);
        core.present(f, w, p, a, a ^ 32'h00000F00);
        #1;
        cmp({27'h0, cause}, {27'h0, exp}, "cause");
        cmp({31'h0, accessAbort}, {31'h0, exp != 5'h00}, "abort");
        cmp(causePc, a ^ 32'h00000F00, "fault pc");
        core.drop();
    endtask : acc
    task automatic t_disabled();
        rd(RPC_OFF_CTRL, 32'h0);
        acc(1'b1, 1'b0, 1'b0, 32'h00050000, 5'h00);
    endtask : t_disabled
    task automatic t_subreg();
        logic [15:0] sel;
        sel = 16'hA0F5;
        for (int k = 0; k < 16; k++) begin
            acc(1'b1, 1'b0, 1'b0, 32'h000103FC + 32'(k) * 32'h400, sel[k] ? 5'h01 : 5'h00);
        end
    endtask : t_subreg
    task automatic t_data();
        acc(1'b0, 1'b1, 1'b0, 32'h00010010, 5'h02);
        acc(1'b0, 1'b0, 1'b1, 32'h00010010, 5'h00);
        acc(1'b0, 1'b1, 1'b1, 32'h00010410, 5'h02);
        acc(1'b0, 1'b1, 1'b0, 32'h00020FFC, 5'h00);
    endtask : t_data
    task automatic t_miss();
        acc(1'b1, 1'b0, 1'b1, 32'h00014000, 5'h04);
        acc(1'b0, 1'b0, 1'b1, 32'h00050000, 5'h08);
    endtask : t_miss
    // Every permission code on region 1, set A: {priv x,w,r, user x,w,r}
    task automatic t_perm();
        logic [5:0] allow [11] = '{6'h08, 6'h28, 6'h18, 6'h38, 6'h09, 6'h2D, 6'h1B, 6'h3F, 6'h19, 6'h1D, 6'h00};
        logic [4:0] exp;
        for (int c = 0; c < 11; c++) begin
            wr(RPC_OFF_PERMA, {24'h0, 4'(c), RPC_AP_RX});
            for (int m = 0; m < 6; m++) begin
                exp = allow[c][m] ? 5'h00 : (m % 3 == 2 ? 5'h01 : 5'h02);
                acc(m % 3 == 2, m % 3 == 1, m >= 3, 32'h00020010, exp);
            end
        end
    endtask : t_perm
    task automatic t_multi();
        wr(RPC_OFF_REGION + 8'h0C, 32'h00020017);
        acc(1'b0, 1'b0, 1'b1, 32'h00020010, 5'h10);
        rd(RPC_OFF_FLTPC, 32'h00020F10);
        rd(RPC_OFF_FLTCAUS, 32'h00000010);
        wr(RPC_OFF_REGION + 8'h0C, 32'h0);
    endtask : t_multi
    task automatic t_irq();
        rd(RPC_OFF_IRQSTAT, 32'h0000001F);
        cmp({31'h0, irq}, 32'h0, "irq masked");
        wr(RPC_OFF_IRQMASK, 32'h00000004);
        cmp({31'h0, irq}, 32'h1, "irq raised");
        wr(RPC_OFF_IRQSTAT, 32'h00000004);
        cmp({31'h0, irq}, 32'h0, "irq cleared");
        rd(RPC_OFF_IRQSTAT, 32'h0000001B);
        rd(8'h3C, 32'h0);
    endtask : t_irq
    initial begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        t_disabled();
        wr(RPC_OFF_REGION, 32'h0001001B);
        wr(RPC_OFF_REGION + 8'h04, 32'h00020017);
        wr(RPC_OFF_REGION + 8'h08, 32'h00050016);
        wr(RPC_OFF_PERMA, {24'h0, 4'h7, RPC_AP_RX});
        wr(RPC_OFF_PERMB, {24'h0, 4'h0, RPC_AP_PR});
        wr(RPC_OFF_SUBSEL, 32'h0000A0F5);
        wr(RPC_OFF_CTRL, 32'h00000001);
        t_subreg();
        t_data();
        t_miss();
        t_perm();
        t_multi();
        t_irq();
        complete_run();
    end
endmodule : tb
`default_nettype wire
